// ---- awd_defines.svh ----
`ifndef AWD_DEFINES_SVH
`define AWD_DEFINES_SVH
// ---------------------------------------------------------------------------
// Summary of operation
// - Enable rising edge captures the scaled live value as reference and arms the window.
// - Live and reference values are scaled as sample times gain plus offset.
// - Output high while enabled and scaled live value is outside the window.
// - Output low when value is back inside the window or enable is low.
// - Gain holds -10.00 to 10.00 in hundredths.
// - Zero offset holds integers from -10000 to 10000.
// - Upper margin above reference holds 0 to 20000.
// - Lower margin below reference holds 0 to 20000.
// - Decimal places 0 to 3 only go to display; never affect comparison.
// - Retentive option keeps reference and output state across power loss.
// - Each margin may come from another block's actual value, by number.
// ---------------------------------------------------------------------------

// ---------------------------------------------------------------------------
// Widths
// ---------------------------------------------------------------------------
`define AWD_ADDR_W     8
`define AWD_DATA_W     32
`define AWD_SMP_W      16
`define AWD_ACT_W      24
`define AWD_MRG_W      15
`define AWD_BLK_W      8

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define AWD_OFS_CTRL   8'h00
`define AWD_OFS_GAIN   8'h04
`define AWD_OFS_ZOFS   8'h08
`define AWD_OFS_MUP    8'h0C
`define AWD_OFS_MLO    8'h10
`define AWD_OFS_SRCUP  8'h14
`define AWD_OFS_SRCLO  8'h18
`define AWD_OFS_REF    8'h1C
`define AWD_OFS_LIVE   8'h20
`define AWD_OFS_STAT   8'h24

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define AWD_CTRL_RET   0
`define AWD_CTRL_DECLO 1
`define AWD_CTRL_DECHI 2
`define AWD_CTRL_UPX   3
`define AWD_CTRL_LOX   4
`define AWD_STAT_Q     0
`define AWD_STAT_EN    1

// ---------------------------------------------------------------------------
// Limits and reset values
// ---------------------------------------------------------------------------
`define AWD_GAIN_MIN   32'shFFFF_FC18
`define AWD_GAIN_MAX   32'sh0000_03E8
`define AWD_ZOFS_MIN   32'shFFFF_D8F0
`define AWD_ZOFS_MAX   32'sh0000_2710
`define AWD_MRG_MAX    32'sh0000_4E20
`define AWD_GAIN_DIV   32'sh0000_0064
`define AWD_GAIN_RST   16'sh0064
`define AWD_ZOFS_RST   16'sh0000
`define AWD_MRG_RST    15'h0000
`define AWD_DEC_RST    2'h0

`endif

// ---- awd_pkg.sv ----
package awd_pkg;
`include "awd_defines.svh"

  typedef struct packed {
    logic                          ret;
    logic [1:0]                    dec;
    logic                          up_ext;
    logic                          lo_ext;
    logic signed [`AWD_SMP_W-1:0]  gain;
    logic signed [`AWD_SMP_W-1:0]  zofs;
    logic [`AWD_MRG_W-1:0]         mup;
    logic [`AWD_MRG_W-1:0]         mlo;
    logic [`AWD_BLK_W-1:0]         src_up;
    logic [`AWD_BLK_W-1:0]         src_lo;
    logic signed [`AWD_ACT_W-1:0]  ref_act;
    logic                          en_prev;
    logic                          q;
    logic [`AWD_DATA_W-1:0]        rdata;
  } awd_state_s;

endpackage

// ---- awd_scaler.sv ----
`timescale 1ns/100ps
`include "awd_defines.svh"
module awd_scaler #(
  parameter int IN_W  = `AWD_SMP_W,
  parameter int OUT_W = `AWD_ACT_W
) (
  input  wire logic signed [IN_W-1:0]  sample_i,
  input  wire logic signed [15:0]      gain_i,
  input  wire logic signed [15:0]      zofs_i,
  output logic signed [OUT_W-1:0]      actual_o
);
  // Gain is in hundredths, so the product is divided by one hundred.
  logic signed [31:0] prod;
  logic signed [31:0] quot;
  logic signed [31:0] sum;

  assign prod     = 32'(sample_i) * 32'(gain_i);
  assign quot     = prod / `AWD_GAIN_DIV;
  assign sum      = quot + 32'(zofs_i);
  assign actual_o = sum[OUT_W-1:0];
endmodule // awd_scaler

// ---- awd_src_model.sv ----
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// Upstream model: live sample and actual values of the margin source blocks
// ---------------------------------------------------------------------------
module awd_src_model (
  input  wire logic               clk_i,
  input  wire logic signed [15:0] target_i,
  input  wire logic [15:0]        step_i,
  input  wire logic signed [15:0] up_val_i,
  input  wire logic signed [15:0] lo_val_i,
  output logic signed [15:0]      sample_o,
  output logic signed [15:0]      up_act_o,
  output logic signed [15:0]      lo_act_o
);
  int d;
  assign d = int'(target_i) - int'(sample_o);
  // A step of zero jumps at once; otherwise the sample slews each cycle.
  always_ff @(posedge clk_i) begin
    up_act_o <= up_val_i;
    lo_act_o <= lo_val_i;
    if (step_i == 16'h0000 || (d <= int'(step_i) && d >= -int'(step_i))) begin
      sample_o <= target_i;
    end else if (d > 0) begin
      sample_o <= sample_o + $signed(step_i);
    end else begin
      sample_o <= sample_o - $signed(step_i);
    end
  end
endmodule // awd_src_model

// ---- awd_watchdog.sv ----
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "awd_defines.svh"
module awd_watchdog
  import awd_pkg::*;
(
  input  wire logic                         core_clk_i,
  input  wire logic                         srst_i,
  input  wire logic                         cold_start_i,
  input  wire logic                         enable_i,
  input  wire logic signed [`AWD_SMP_W-1:0] analog_sample_in_i,
  input  wire logic signed [`AWD_SMP_W-1:0] ext_margin_up_i,
  input  wire logic signed [`AWD_SMP_W-1:0] ext_margin_lo_i,
  input  wire logic [`AWD_ADDR_W-1:0]       reg_addr_i,
  input  wire logic [`AWD_DATA_W-1:0]       reg_wdata_i,
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  output logic [`AWD_DATA_W-1:0]            reg_rdata_o,
  output logic                              alarm_q_o,
  output logic [1:0]                        decimals_o,
  output logic [`AWD_BLK_W-1:0]             margin_src_up_o,
  output logic [`AWD_BLK_W-1:0]             margin_src_lo_o
);

  // -------------------------------------------------------------------------
  // Saturating helpers for parameter writes and sourced margins.
  // -------------------------------------------------------------------------
  function automatic logic signed [15:0] sat16(
    input logic signed [31:0] v,
    input logic signed [31:0] lo,
    input logic signed [31:0] hi
  );
    logic signed [31:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r[15:0];
  endfunction

  function automatic logic [`AWD_MRG_W-1:0] sat_mrg(
    input logic signed [31:0] v
  );
    logic signed [31:0] r;
    r = v;
    if (v < 32'sh0000_0000) begin
      r = 32'sh0000_0000;
    end else if (v > `AWD_MRG_MAX) begin
      r = `AWD_MRG_MAX;
    end
    return r[`AWD_MRG_W-1:0];
  endfunction

  // -------------------------------------------------------------------------
  // State and datapath signals.
  // -------------------------------------------------------------------------
  awd_state_s                     st_reg;
  awd_state_s                     st_next;
  awd_state_s                     st_warm;
  awd_state_s                     st_cold;
  logic                           en_rise;
  logic signed [`AWD_ACT_W-1:0]   live_act;
  logic signed [`AWD_ACT_W-1:0]   ref_eff;
  logic [`AWD_MRG_W-1:0]          mup_eff;
  logic [`AWD_MRG_W-1:0]          mlo_eff;
  logic signed [`AWD_ACT_W+1:0]   win_top;
  logic signed [`AWD_ACT_W+1:0]   win_bot;
  logic                           outside;
  logic signed [31:0]             wsig;

  // -------------------------------------------------------------------------
  // Scaling, edge detect and window.
  // -------------------------------------------------------------------------
  awd_scaler #(
    .IN_W  (`AWD_SMP_W),
    .OUT_W (`AWD_ACT_W)
  ) u_scaler (
    .sample_i (analog_sample_in_i),
    .gain_i   (st_reg.gain),
    .zofs_i   (st_reg.zofs),
    .actual_o (live_act)
  );

  assign en_rise = enable_i & ~st_reg.en_prev;
  // The window opens around the value being captured in the edge cycle.
  assign ref_eff = en_rise ? live_act : st_reg.ref_act;
  assign mup_eff = st_reg.up_ext ?
                   sat_mrg(32'(ext_margin_up_i)) : st_reg.mup;
  assign mlo_eff = st_reg.lo_ext ?
                   sat_mrg(32'(ext_margin_lo_i)) : st_reg.mlo;
  assign wsig    = reg_wdata_i;

  awd_window #(
    .ACT_W (`AWD_ACT_W),
    .MRG_W (`AWD_MRG_W)
  ) u_window (
    .value_i   (live_act),
    .ref_i     (ref_eff),
    .mup_i     (mup_eff),
    .mlo_i     (mlo_eff),
    .top_o     (win_top),
    .bot_o     (win_bot),
    .outside_o (outside)
  );

  // -------------------------------------------------------------------------
  // Reset images.
  // -------------------------------------------------------------------------
  always_comb begin
    st_cold         = '0;
    st_cold.dec     = `AWD_DEC_RST;
    st_cold.gain    = `AWD_GAIN_RST;
    st_cold.zofs    = `AWD_ZOFS_RST;
    st_cold.mup     = `AWD_MRG_RST;
    st_cold.mlo     = `AWD_MRG_RST;
    st_warm         = st_reg;
    st_warm.rdata   = '0;
    if (!st_reg.ret) begin
      st_warm.ref_act = '0;
      st_warm.en_prev = 1'b0;
      st_warm.q       = 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // Next state: evaluation, register writes and reads.
  // -------------------------------------------------------------------------
  always_comb begin
    st_next         = st_reg;
    st_next.en_prev = enable_i;
    if (en_rise) begin
      st_next.ref_act = live_act;
    end
    st_next.q = enable_i & outside;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `AWD_OFS_CTRL: begin
          st_next.ret    = reg_wdata_i[`AWD_CTRL_RET];
          st_next.dec    = reg_wdata_i[`AWD_CTRL_DECHI:`AWD_CTRL_DECLO];
          st_next.up_ext = reg_wdata_i[`AWD_CTRL_UPX];
          st_next.lo_ext = reg_wdata_i[`AWD_CTRL_LOX];
        end
        `AWD_OFS_GAIN: begin
          st_next.gain = sat16(wsig, `AWD_GAIN_MIN, `AWD_GAIN_MAX);
        end
        `AWD_OFS_ZOFS: begin
          st_next.zofs = sat16(wsig, `AWD_ZOFS_MIN, `AWD_ZOFS_MAX);
        end
        `AWD_OFS_MUP: begin
          st_next.mup = sat_mrg(wsig);
        end
        `AWD_OFS_MLO: begin
          st_next.mlo = sat_mrg(wsig);
        end
        `AWD_OFS_SRCUP: begin
          st_next.src_up = reg_wdata_i[`AWD_BLK_W-1:0];
        end
        `AWD_OFS_SRCLO: begin
          st_next.src_lo = reg_wdata_i[`AWD_BLK_W-1:0];
        end
        default: begin
        end
      endcase
    end
    st_next.rdata = '0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `AWD_OFS_CTRL: begin
          st_next.rdata[`AWD_CTRL_RET]                 = st_reg.ret;
          st_next.rdata[`AWD_CTRL_DECHI:`AWD_CTRL_DECLO] = st_reg.dec;
          st_next.rdata[`AWD_CTRL_UPX]                 = st_reg.up_ext;
          st_next.rdata[`AWD_CTRL_LOX]                 = st_reg.lo_ext;
        end
        `AWD_OFS_GAIN:  st_next.rdata = 32'(st_reg.gain);
        `AWD_OFS_ZOFS:  st_next.rdata = 32'(st_reg.zofs);
        `AWD_OFS_MUP:   st_next.rdata = 32'(mup_eff);
        `AWD_OFS_MLO:   st_next.rdata = 32'(mlo_eff);
        `AWD_OFS_SRCUP: st_next.rdata = 32'(st_reg.src_up);
        `AWD_OFS_SRCLO: st_next.rdata = 32'(st_reg.src_lo);
        `AWD_OFS_REF:   st_next.rdata = 32'(st_reg.ref_act);
        `AWD_OFS_LIVE:  st_next.rdata = 32'(live_act);
        `AWD_OFS_STAT: begin
          st_next.rdata[`AWD_STAT_Q]  = st_reg.q;
          st_next.rdata[`AWD_STAT_EN] = st_reg.en_prev;
        end
        default: begin
          st_next.rdata = '0;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // State register.
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i && cold_start_i) begin
      st_reg <= st_cold;
    end else if (srst_i) begin
      st_reg <= st_warm;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o     = st_reg.rdata;
  assign alarm_q_o       = st_reg.q;
  assign decimals_o      = st_reg.dec;
  assign margin_src_up_o = st_reg.src_up;
  assign margin_src_lo_o = st_reg.src_lo;

  // -------------------------------------------------------------------------
  // Assertions.
  // -------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  a_edge_capture: assert property (
    !srst_i && en_rise |=> (st_reg.ref_act == $past(live_act)))
    else $error("reference not captured on enable edge");

  a_ref_hold: assert property (
    !srst_i && !en_rise |=> $stable(st_reg.ref_act))
    else $error("reference changed without enable edge");

  a_scale_live: assert property (
    (st_reg.gain == `AWD_GAIN_RST) && (st_reg.zofs == 16'sh0000)
      |-> (live_act == `AWD_ACT_W'(analog_sample_in_i)))
    else $error("unity scaling does not pass sample through");

  a_out_above: assert property (
    !srst_i && enable_i && (32'(live_act) > 32'(win_top)) |=> alarm_q_o)
    else $error("output low above window");

  a_out_below: assert property (
    !srst_i && enable_i && (32'(live_act) < 32'(win_bot)) |=> alarm_q_o)
    else $error("output low below window");

  a_en_low_clr: assert property (
    !srst_i && !enable_i |=> !alarm_q_o ##1 (!alarm_q_o || $past(enable_i)))
    else $error("output high with enable low");

  a_gain_range: assert property (
    (32'(st_reg.gain) >= `AWD_GAIN_MIN) &&
    (32'(st_reg.gain) <= `AWD_GAIN_MAX))
    else $error("gain out of range");

  a_zofs_range: assert property (
    (32'(st_reg.zofs) >= `AWD_ZOFS_MIN) &&
    (32'(st_reg.zofs) <= `AWD_ZOFS_MAX))
    else $error("offset out of range");

  a_mrg_range: assert property (
    (32'(mup_eff) <= `AWD_MRG_MAX) && (32'(mlo_eff) <= `AWD_MRG_MAX))
    else $error("margin out of range");

  a_ext_margin: assert property (
    st_reg.up_ext && (ext_margin_up_i < 16'sh0000) |-> (mup_eff == '0))
    else $error("negative sourced margin not clipped");

  a_edge_quiet: assert property (
    !srst_i && en_rise |=> !alarm_q_o)
    else $error("output set in capture cycle");

  a_bound_in: assert property (
    !srst_i && enable_i && ((32'(live_act) == 32'(win_top)) ||
                 (32'(live_act) == 32'(win_bot))) |=> !alarm_q_o)
    else $error("value on bound treated as outside");

  a_rd_status: assert property (
    !srst_i && reg_rd_i && (reg_addr_i == `AWD_OFS_STAT)
      |=> (reg_rdata_o[`AWD_STAT_Q] == $past(alarm_q_o)))
    else $error("status read does not show output");

  // -------------------------------------------------------------------------
  // Margin, window, enable, register and reset assertions.
  // -------------------------------------------------------------------------
  a_ext_lo_clip: assert property (
    st_reg.lo_ext && (ext_margin_lo_i < 16'sh0000) |-> (mlo_eff == '0))
    else $error("negative sourced lower margin not clipped");

  a_ext_up_pass: assert property (
    st_reg.up_ext && (32'(ext_margin_up_i) >= 32'sh0000_0000) &&
    (32'(ext_margin_up_i) <= `AWD_MRG_MAX)
      |-> (32'(mup_eff) == 32'(ext_margin_up_i)))
    else $error("sourced upper margin not passed through");

  a_in_window: assert property (
    !srst_i && enable_i && (32'(live_act) <= 32'(win_top)) &&
    (32'(live_act) >= 32'(win_bot)) |=> !alarm_q_o)
    else $error("output high inside window");

  a_en_history: assert property (
    !srst_i |=> (st_reg.en_prev == $past(enable_i)))
    else $error("enable level not recorded");

  a_dec_write: assert property (
    !srst_i && reg_wr_i && (reg_addr_i == `AWD_OFS_CTRL)
      |=> (decimals_o ==
           $past(reg_wdata_i[`AWD_CTRL_DECHI:`AWD_CTRL_DECLO])))
    else $error("decimals not taken from control write");

  a_src_lo_write: assert property (
    !srst_i && reg_wr_i && (reg_addr_i == `AWD_OFS_SRCLO)
      |=> (margin_src_lo_o == $past(reg_wdata_i[`AWD_BLK_W-1:0])))
    else $error("lower source block number not stored");

  a_mup_write: assert property (
    !srst_i && reg_wr_i && (reg_addr_i == `AWD_OFS_MUP) &&
    ($signed(reg_wdata_i) >= 0) && ($signed(reg_wdata_i) <= `AWD_MRG_MAX)
      |=> (32'(st_reg.mup) == $past(reg_wdata_i)))
    else $error("upper margin write not stored");

  a_mlo_write: assert property (
    !srst_i && reg_wr_i && (reg_addr_i == `AWD_OFS_MLO) &&
    ($signed(reg_wdata_i) >= 0) && ($signed(reg_wdata_i) <= `AWD_MRG_MAX)
      |=> (32'(st_reg.mlo) == $past(reg_wdata_i)))
    else $error("lower margin write not stored");

  a_cold_image: assert property (
    disable iff (1'b0)
    srst_i && cold_start_i
      |=> (st_reg.gain == `AWD_GAIN_RST) && (st_reg.ref_act == '0) &&
          !alarm_q_o)
    else $error("cold reset image wrong");

  a_warm_keep: assert property (
    disable iff (1'b0)
    srst_i && !cold_start_i && st_reg.ret
      |=> (st_reg.ref_act == $past(st_reg.ref_act)) &&
          (alarm_q_o == $past(alarm_q_o)))
    else $error("retained state lost on warm reset");

  a_warm_clear: assert property (
    disable iff (1'b0)
    srst_i && !cold_start_i && !st_reg.ret
      |=> (st_reg.ref_act == '0) && !alarm_q_o && !st_reg.en_prev)
    else $error("unretained state kept on warm reset");

  c_capture: cover property (en_rise ##1 enable_i [*2]);
  c_alarm_rise: cover property (enable_i ##1 $rose(alarm_q_o));
  c_alarm_back: cover property (alarm_q_o && enable_i ##1 !alarm_q_o);
  c_ext_margin: cover property (st_reg.up_ext && alarm_q_o);
  c_warm_keep: cover property (
    disable iff (1'b0) srst_i && !cold_start_i && st_reg.ret);

endmodule // awd_watchdog

// ---- awd_window.sv ----
`timescale 1ns/100ps
`include "awd_defines.svh"
module awd_window #(
  parameter int ACT_W = `AWD_ACT_W,
  parameter int MRG_W = `AWD_MRG_W
) (
  input  wire logic signed [ACT_W-1:0] value_i,
  input  wire logic signed [ACT_W-1:0] ref_i,
  input  wire logic [MRG_W-1:0]        mup_i,
  input  wire logic [MRG_W-1:0]        mlo_i,
  output logic signed [ACT_W+1:0]      top_o,
  output logic signed [ACT_W+1:0]      bot_o,
  output logic                         outside_o
);
  logic signed [ACT_W+1:0] val_w;

  assign val_w     = (ACT_W+2)'(value_i);
  assign top_o     = (ACT_W+2)'(ref_i) + (ACT_W+2)'({1'b0, mup_i});
  assign bot_o     = (ACT_W+2)'(ref_i) - (ACT_W+2)'({1'b0, mlo_i});
  // Bounds themselves count as inside.
  assign outside_o = (val_w > top_o) || (val_w < bot_o);
endmodule // awd_window

// ---- tb.sv ----
`timescale 1ns/100ps
module tb;
  import awd_pkg::*;
  typedef struct {
    int g, o, up, lo, sref, slive, q;
  } awd_row_s;
  logic               clk, srst, cold, en, wr, rd;
  logic signed [15:0] tgt, upv, lov, smp, upa, loa;
  logic [15:0]        step;
  logic [7:0]         addr, sup, slo;
  logic [31:0]        wdata, rdata, rv;
  logic               q;
  logic [1:0]         dec;
  int                 failures, num_checks;
  awd_row_s rows[8] = '{
    '{100, 0, 10, 10, 500, 510, 0}, '{100, 0, 10, 10, 500, 511, 1},
    '{100, 0, 10, 10, 500, 490, 0}, '{100, 0, 10, 10, 500, 489, 1},
    '{250, -30, 0, 0, 200, 200, 0}, '{-150, 100, 20, 5, 100, 110, 1},
    '{33, 7, 0, 3, -101, -110, 0}, '{1000, 10000, 20000, 20000, 3000, 0, 1}};
  int rst_a[8] = '{0, 4, 8, 12, 16, 28, 36, 48};
  int rst_e[8] = '{0, 100, 0, 0, 0, 0, 0, 0};
  int sat_a[6] = '{4, 4, 8, 8, 12, 16};
  int sat_d[6] = '{2000, -2000, 20000, -20000, 30000, 30000};
  int sat_e[6] = '{1000, -1000, 10000, -10000, 20000, 20000};

  awd_src_model u_src (.clk_i(clk), .target_i(tgt), .step_i(step),
    .up_val_i(upv), .lo_val_i(lov), .sample_o(smp), .up_act_o(upa),
    .lo_act_o(loa));
  awd_watchdog u_dut (.core_clk_i(clk), .srst_i(srst), .cold_start_i(cold),
    .enable_i(en), .analog_sample_in_i(smp), .ext_margin_up_i(upa),
    .ext_margin_lo_i(loa), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .alarm_q_o(q),
    .decimals_o(dec), .margin_src_up_o(sup), .margin_src_lo_o(slo));

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  function automatic int sc(int s, int g, int o);
    return s * g / 100 + o;
  endfunction
  task automatic chk(string nm, int e, logic [31:0] got);
    num_checks++;
    if (got !== 32'(e)) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, 32'(e), got);
    end
  endtask
  task automatic wr_reg(int a, int d);
    @(posedge clk);
    addr <= 8'(a);
    wdata <= 32'(d);
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(int a, output logic [31:0] v);
    @(posedge clk);
    addr <= 8'(a);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic arm(int s);
    @(posedge clk);
    en <= 1'b0;
    tgt <= 16'(s);
    repeat (2) @(posedge clk);
    en <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic live_chk(int s, int e, int n);
    @(posedge clk);
    tgt <= 16'(s);
    repeat (n) @(posedge clk);
    #1 chk("alarm", e, {31'h0, q});
  endtask
  task automatic warm(int ctrl, int e);
    wr_reg(0, ctrl);
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1 chk("alarm_warm", e, {31'h0, q});
  endtask
  task automatic close_out();
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Clock, watchdog and tests
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    close_out();
  end
  initial begin
    {srst, cold, en, wr, rd} = 5'h18;
    {tgt, upv, lov, step} = '0;
    addr = '0;
    wdata = '0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    cold <= 1'b0;
    foreach (rst_a[i]) begin
      rd_reg(rst_a[i], rv);
      chk("reset_read", rst_e[i], rv);
    end
    foreach (sat_a[i]) begin
      wr_reg(sat_a[i], sat_d[i]);
      rd_reg(sat_a[i], rv);
      chk("saturate", sat_e[i], rv);
    end
    foreach (rows[i]) begin
      wr_reg(4, rows[i].g);
      wr_reg(8, rows[i].o);
      wr_reg(12, rows[i].up);
      wr_reg(16, rows[i].lo);
      arm(rows[i].sref);
      live_chk(rows[i].slive, rows[i].q, 3);
      rd_reg(28, rv);
      chk("ref", sc(rows[i].sref, rows[i].g, rows[i].o), rv);
      rd_reg(32, rv);
      chk("live", sc(rows[i].slive, rows[i].g, rows[i].o), rv);
    end
    wr_reg(0, 6);
    live_chk(0, 1, 3);
    chk("decimals", 3, {30'h0, dec});
    rd_reg(36, rv);
    chk("status", 3, rv);
    @(posedge clk);
    en <= 1'b0;
    live_chk(0, 0, 3);
    wr_reg(4, 100);
    wr_reg(8, 0);
    wr_reg(12, 0);
    wr_reg(16, 0);
    wr_reg(20, 42);
    upv <= 16'sh0032;
    wr_reg(0, 8);
    chk("src_up", 42, {24'h0, sup});
    arm(100);
    live_chk(140, 0, 3);
    upv <= 16'sh001E;
    live_chk(140, 1, 3);
    step <= 16'h0004;
    live_chk(112, 0, 10);
    live_chk(140, 1, 10);
    warm(9, 1);
    rd_reg(28, rv);
    chk("ref_kept", 100, rv);
    rd_reg(4, rv);
    chk("gain_kept", 100, rv);
    warm(8, 0);
    step <= 16'h0000;
    upv <= 16'shFFF6;
    lov <= 16'sh0014;
    wr_reg(24, 7);
    wr_reg(0, 24);
    chk("src_lo", 7, {24'h0, slo});
    rd_reg(12, rv);
    chk("mup_clip", 0, rv);
    rd_reg(16, rv);
    chk("mlo_ext", 20, rv);
    arm(100);
    live_chk(80, 0, 3);
    live_chk(79, 1, 3);
    live_chk(101, 1, 3);
    lov <= 16'shFFF0;
    live_chk(81, 1, 3);
    close_out();
  end
endmodule // tb
